/* File: logic/exec_pkg.sv */
package exec_pkg;

	// ****************************************
	// Flag positions in the core flag register
	// ****************************************
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;

	// ****************************************
	// Widths, steps and cycle counts
	// ****************************************
	localparam int DATA_W = 8;
	localparam int PC_W = 16;
	localparam int OFFS_W = 7;
	localparam logic [15:0] PC_STEP_NEXT = 16'h0001;
	localparam logic [15:0] PC_STEP_SKIP_ONE = 16'h0002;
	localparam logic [15:0] PC_STEP_SKIP_TWO = 16'h0003;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [1:0] CYC_PLAIN = 2'h1;
	localparam logic [1:0] CYC_SKIP_ONE = 2'h2;
	localparam logic [1:0] CYC_SKIP_TWO = 2'h3;
	localparam logic [1:0] CYC_BRANCH_TAKEN = 2'h2;
	localparam logic [1:0] CNT_RESET = 2'h0;

	typedef enum logic [3:0] {
		OP_CMP_CARRY,
		OP_CMP_IMM,
		OP_SKIP_REG_BIT_CLEAR,
		OP_SKIP_REG_BIT_SET,
		OP_SKIP_IO_BIT_CLEAR,
		OP_SKIP_IO_BIT_SET,
		OP_BRANCH_FLAG_SET,
		OP_BRANCH_FLAG_CLEAR,
		OP_BRANCH_EQUAL
	} op_t;

	typedef enum logic {
		PH_IDLE,
		PH_BUSY
	} phase_t;

	typedef struct packed {
		op_t op;
		logic [7:0] first_val;
		logic [7:0] second_val;
		logic [7:0] imm;
		logic [7:0] io_val;
		logic [2:0] bit_sel;
		logic [6:0] offset;
		logic next_two_words;
		logic [15:0] pc;
		logic [7:0] flags;
	} exec_req_t;

	typedef struct packed {
		logic [7:0] flags;
		logic [15:0] pc;
	} exec_res_t;

	typedef struct packed {
		logic z;
		logic n;
		logic v;
		logic c;
		logic h;
	} sub_flags_t;

	typedef struct packed {
		phase_t phase;
		logic [1:0] cnt;
		logic done;
		logic flags_we;
		exec_res_t res;
	} exec_state_t;

endpackage

/* File: logic/bit_pick.sv */
`timescale 1ns/1ps
module bit_pick (
	input wire logic [7:0] value,
	input wire logic [2:0] sel,
	output logic bit_out
);
	always_comb begin
		bit_out = value[sel];
	end
endmodule

/* File: logic/sub8_flags.sv */
`timescale 1ns/1ps
module sub8_flags (
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic borrow_in,
	output exec_pkg::sub_flags_t flags
);
	import exec_pkg::*;

	logic [8:0] full;
	logic [4:0] low;

	// Difference only feeds the flags; it is never stored
	always_comb begin
		full = {1'b0, a} - {1'b0, b} - {8'h00, borrow_in};
		low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, borrow_in};
		flags.z = (full[7:0] == 8'h00);
		flags.n = full[7];
		flags.v = (a[7] & ~b[7] & ~full[7]) | (~a[7] & b[7] & full[7]);
		flags.c = full[8];
		flags.h = low[4];
	end
endmodule

/* File: logic/compare_skip_branch_exec.sv */
`timescale 1ns/1ps
module compare_skip_branch_exec (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req_valid,
	input exec_pkg::exec_req_t req,
	output logic req_ready,
	output logic done,
	output logic flags_we,
	output logic pc_load,
	output exec_pkg::exec_res_t res
);
	import exec_pkg::*;

	// ****************************************
	// Operand selection
	// ****************************************
	exec_state_t st_q;
	exec_state_t st_d;
	sub_flags_t cmp_flags;
	logic [7:0] cmp_b;
	logic cmp_borrow;
	logic reg_bit;
	logic io_bit;
	logic core_bit;
	logic take;
	logic cond;
	logic is_cmp;
	logic is_skip;
	logic [15:0] offs_ext;
	logic [15:0] pc_taken;
	logic [7:0] new_flags;

	assign take = req_valid && req_ready;

	always_comb begin
		cmp_b = req.second_val;
		cmp_borrow = req.flags[FLAG_C];
		if (req.op == OP_CMP_IMM) begin
			cmp_b = req.imm;
			cmp_borrow = 1'b0;
		end
	end

	sub8_flags u_sub (
		.a(req.first_val),
		.b(cmp_b),
		.borrow_in(cmp_borrow),
		.flags(cmp_flags)
	);

	bit_pick u_reg_bit (
		.value(req.first_val),
		.sel(req.bit_sel),
		.bit_out(reg_bit)
	);

	bit_pick u_io_bit (
		.value(req.io_val),
		.sel(req.bit_sel),
		.bit_out(io_bit)
	);

	bit_pick u_core_bit (
		.value(req.flags),
		.sel(req.bit_sel),
		.bit_out(core_bit)
	);

	// ****************************************
	// Condition and targets
	// ****************************************
	// Signed word offset
	assign offs_ext = {{(PC_W - OFFS_W){req.offset[OFFS_W - 1]}}, req.offset};
	assign pc_taken = req.pc + offs_ext + PC_STEP_NEXT;

	always_comb begin
		is_cmp = 1'b0;
		is_skip = 1'b0;
		cond = 1'b0;
		unique case (req.op)
			OP_CMP_CARRY, OP_CMP_IMM: begin
				is_cmp = 1'b1;
			end
			OP_SKIP_REG_BIT_CLEAR: begin
				is_skip = 1'b1;
				cond = ~reg_bit;
			end
			OP_SKIP_REG_BIT_SET: begin
				is_skip = 1'b1;
				cond = reg_bit;
			end
			OP_SKIP_IO_BIT_CLEAR: begin
				is_skip = 1'b1;
				cond = ~io_bit;
			end
			OP_SKIP_IO_BIT_SET: begin
				is_skip = 1'b1;
				cond = io_bit;
			end
			OP_BRANCH_FLAG_SET: begin
				cond = core_bit;
			end
			OP_BRANCH_FLAG_CLEAR: begin
				cond = ~core_bit;
			end
			OP_BRANCH_EQUAL: begin
				cond = req.flags[FLAG_Z];
			end
			default: begin
				cond = 1'b0;
			end
		endcase
	end

	always_comb begin
		new_flags = req.flags;
		new_flags[FLAG_Z] = cmp_flags.z;
		new_flags[FLAG_N] = cmp_flags.n;
		new_flags[FLAG_V] = cmp_flags.v;
		new_flags[FLAG_C] = cmp_flags.c;
		new_flags[FLAG_H] = cmp_flags.h;
	end

	// ****************************************
	// Sequencing
	// ****************************************
	always_comb begin
		logic [1:0] cycles;
		cycles = CYC_PLAIN;
		st_d = st_q;
		st_d.done = 1'b0;
		st_d.flags_we = 1'b0;
		unique case (st_q.phase)
			PH_IDLE: begin
				if (take) begin
					st_d.res.flags = req.flags;
					st_d.res.pc = req.pc + PC_STEP_NEXT;
					if (is_cmp) begin
						st_d.res.flags = new_flags;
					end else if (is_skip && cond) begin
						if (req.next_two_words) begin
							st_d.res.pc = req.pc + PC_STEP_SKIP_TWO;
							cycles = CYC_SKIP_TWO;
						end else begin
							st_d.res.pc = req.pc + PC_STEP_SKIP_ONE;
							cycles = CYC_SKIP_ONE;
						end
					end else if (!is_skip && cond) begin
						st_d.res.pc = pc_taken;
						cycles = CYC_BRANCH_TAKEN;
					end
					st_d.cnt = cycles - CYC_PLAIN;
					if (cycles == CYC_PLAIN) begin
						st_d.done = 1'b1;
						st_d.flags_we = is_cmp;
					end else begin
						st_d.phase = PH_BUSY;
					end
				end
			end
			PH_BUSY: begin
				st_d.cnt = st_q.cnt - 2'h1;
				if (st_q.cnt == 2'h1) begin
					st_d.done = 1'b1;
					st_d.phase = PH_IDLE;
				end
			end
		endcase
	end

	// Results held until the next instruction is accepted
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q.phase <= PH_IDLE;
			st_q.cnt <= CNT_RESET;
			st_q.done <= 1'b0;
			st_q.flags_we <= 1'b0;
			st_q.res.flags <= FLAGS_RESET;
			st_q.res.pc <= PC_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	assign req_ready = (st_q.phase == PH_IDLE);
	assign done = st_q.done;
	assign pc_load = st_q.done;
	assign flags_we = st_q.flags_we;
	assign res = st_q.res;

	// ****************************************
	// Checks
	// ****************************************
	a_cmp_carry_one:
	assert property (@(posedge clk) disable iff (!rst_n)
		take && req.op == OP_CMP_CARRY |=> done && flags_we
			&& res.flags[FLAG_S] == $past(req.flags[FLAG_S]))
	else $error("compare with carry not one cycle");

	a_cmp_imm_zero:
	assert property (@(posedge clk) disable iff (!rst_n)
		take && req.op == OP_CMP_IMM && req.first_val == req.imm
			|=> flags_we && res.flags[FLAG_Z] && !res.flags[FLAG_C])
	else $error("compare immediate equal did not set zero");

	a_skip_reg_clear:
	assert property (@(posedge clk) disable iff (!rst_n)
		take && req.op == OP_SKIP_REG_BIT_CLEAR && !reg_bit && !req.next_two_words
			|=> !done ##1 (done && res.pc == $past(req.pc, 2) + PC_STEP_SKIP_ONE))
	else $error("register bit clear skip wrong");

	a_skip_reg_set:
	assert property (@(posedge clk) disable iff (!rst_n)
		take && req.op == OP_SKIP_REG_BIT_SET && reg_bit && req.next_two_words
			|=> (!done && !flags_we)[*2] ##1 (done && !flags_we
			&& res.pc == $past(req.pc, 3) + PC_STEP_SKIP_TWO))
	else $error("register bit set skip wrong");

	a_skip_io_clear:
	assert property (@(posedge clk) disable iff (!rst_n)
		take && req.op == OP_SKIP_IO_BIT_CLEAR && io_bit
			|=> done && !flags_we && res.pc == $past(req.pc) + PC_STEP_NEXT)
	else $error("I/O bit clear wrongly skipped");

	a_skip_io_set:
	assert property (@(posedge clk) disable iff (!rst_n)
		take && req.op == OP_SKIP_IO_BIT_SET && io_bit && !req.next_two_words
			|-> ##2 (done && !flags_we && res.pc == $past(req.pc, 2) + PC_STEP_SKIP_ONE))
	else $error("I/O bit set skip wrong");

	a_skip_busy_len:
	assert property (@(posedge clk) disable iff (!rst_n)
		take && is_skip && cond |=> !req_ready ##1 (done || !req_ready))
	else $error("skip released early");

	a_branch_set_pc:
	assert property (@(posedge clk) disable iff (!rst_n)
		take && req.op == OP_BRANCH_FLAG_SET && core_bit
			|-> ##2 (done && res.pc == $past(req.pc, 2)
			+ {{9{$past(req.offset[6], 2)}}, $past(req.offset, 2)} + PC_STEP_NEXT))
	else $error("branch on flag set wrong target");

	a_branch_clr_seq:
	assert property (@(posedge clk) disable iff (!rst_n)
		take && req.op == OP_BRANCH_FLAG_CLEAR && core_bit
			|=> done && !flags_we && res.pc == $past(req.pc) + PC_STEP_NEXT)
	else $error("branch on flag clear not sequential");

	a_branch_eq_take:
	assert property (@(posedge clk) disable iff (!rst_n)
		take && req.op == OP_BRANCH_EQUAL && req.flags[FLAG_Z]
			|=> !done ##1 (done && res.pc == $past(req.pc, 2)
			+ {{9{$past(req.offset[6], 2)}}, $past(req.offset, 2)} + PC_STEP_NEXT))
	else $error("branch equal wrong target");

	a_branch_cost:
	assert property (@(posedge clk) disable iff (!rst_n)
		take && !is_cmp && !is_skip && cond |=> !done && !req_ready ##1 done)
	else $error("taken branch cost wrong");

	a_ready_done:
	assert property (@(posedge clk) disable iff (!rst_n)
		done |-> req_ready && $past(st_q.phase == PH_BUSY || take))
	else $error("done without instruction");

	a_cmp_carry_borrow:
	assert property (@(posedge clk) disable iff (!rst_n)
		take && req.op == OP_CMP_CARRY
			|=> res.flags[FLAG_C] == $past(int'(req.first_val)
			< int'(req.second_val) + int'(req.flags[FLAG_C])))
	else $error("compare with carry borrow wrong");

	a_cmp_imm_flags:
	assert property (@(posedge clk) disable iff (!rst_n)
		take && req.op == OP_CMP_IMM
			|=> done && flags_we && res.flags[FLAG_C] == $past(req.first_val < req.imm)
			&& res.flags[FLAG_N] == $past(8'(req.first_val - req.imm) >= 8'h80))
	else $error("compare immediate flags wrong");

	a_branch_not_taken:
	assert property (@(posedge clk) disable iff (!rst_n)
		take && !is_cmp && !is_skip && !cond
			|=> done && !flags_we && res.pc == $past(req.pc) + PC_STEP_NEXT)
	else $error("branch not taken wrong");

endmodule

/* File: testbench/test_compare_skip_branch_exec.sv */
`timescale 1ns/1ps
module test_compare_skip_branch_exec;
	import exec_pkg::*;

	// ****************************************
	// Clock, reset and design
	// ****************************************
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	exec_req_t req = '0;
	logic req_ready;
	logic done;
	logic flags_we;
	logic pc_load;
	exec_res_t res;
	int fails = 0;
	int checked = 0;
	int seed = 77159;

	always #2.5 clk = ~clk;

	compare_skip_branch_exec dut (
		.clk(clk),
		.rst_n(rst_n),
		.req_valid(req_valid),
		.req(req),
		.req_ready(req_ready),
		.done(done),
		.flags_we(flags_we),
		.pc_load(pc_load),
		.res(res)
	);

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic conclude();
		if (fails == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic rand_req(output exec_req_t r);
		logic [95:0] raw;
		raw = {$random(seed), $random(seed), $random(seed)};
		r = raw[70:0];
		r.op = op_t'(($random(seed) & 32'h7fff_ffff) % 9);
	endtask

	// ****************************************
	// Reference model
	// ****************************************
	task automatic model(input exec_req_t r, output logic [15:0] pc, output logic [7:0] fl,
			output int cyc, output logic we);
		int a;
		int b;
		int d;
		int sr;
		int off;
		logic [7:0] q;
		logic cond;
		pc = r.pc + 16'h0001;
		fl = r.flags;
		cyc = 1;
		we = 1'b0;
		cond = 1'b0;
		off = r.offset[6] ? int'(r.offset) - 128 : int'(r.offset);
		case (r.op)
			OP_CMP_CARRY, OP_CMP_IMM: begin
				a = r.first_val;
				b = (r.op == OP_CMP_CARRY) ? r.second_val : r.imm;
				d = (r.op == OP_CMP_CARRY) ? r.flags[FLAG_C] : 0;
				q = 8'(a - b - d);
				sr = (a > 127 ? a - 256 : a) - (b > 127 ? b - 256 : b) - d;
				fl[FLAG_C] = a < b + d;
				fl[FLAG_Z] = q == 8'h00;
				fl[FLAG_N] = q[7];
				fl[FLAG_V] = sr < -128 || sr > 127;
				fl[FLAG_H] = (a % 16) < (b % 16) + d;
				we = 1'b1;
			end
			OP_SKIP_REG_BIT_CLEAR: cond = !r.first_val[r.bit_sel];
			OP_SKIP_REG_BIT_SET: cond = r.first_val[r.bit_sel];
			OP_SKIP_IO_BIT_CLEAR: cond = !r.io_val[r.bit_sel];
			OP_SKIP_IO_BIT_SET: cond = r.io_val[r.bit_sel];
			OP_BRANCH_FLAG_SET: cond = r.flags[r.bit_sel];
			OP_BRANCH_FLAG_CLEAR: cond = !r.flags[r.bit_sel];
			OP_BRANCH_EQUAL: cond = r.flags[FLAG_Z];
			default: cond = 1'b0;
		endcase
		if (cond && r.op inside {[OP_SKIP_REG_BIT_CLEAR:OP_SKIP_IO_BIT_SET]}) begin
			pc = r.pc + (r.next_two_words ? 16'h0003 : 16'h0002);
			cyc = r.next_two_words ? 3 : 2;
		end
		if (cond && r.op inside {[OP_BRANCH_FLAG_SET:OP_BRANCH_EQUAL]}) begin
			pc = 16'(int'(r.pc) + off + 1);
			cyc = 2;
		end
	endtask

	// One instruction; junk held on the request while busy must be refused
	task automatic run(input exec_req_t r);
		logic [15:0] epc;
		logic [7:0] efl;
		int ecyc;
		logic ewe;
		int n;
		exec_req_t junk;
		model(r, epc, efl, ecyc, ewe);
		req = r;
		req_valid = 1'b1;
		@(posedge clk);
		#1;
		n = 1;
		while (done !== 1'b1 && n <= 4) begin
			check("req_ready while busy", 16'h0000, {15'h0000, req_ready});
			check("flags_we while busy", 16'h0000, {15'h0000, flags_we});
			rand_req(junk);
			req = junk;
			@(posedge clk);
			#1;
			n++;
		end
		if (n > 4) begin
			fails++;
			conclude();
		end
		check("cycles", 16'(ecyc), 16'(n));
		check("res.pc", epc, res.pc);
		check("res.flags", {8'h00, efl}, {8'h00, res.flags});
		check("flags_we", {15'h0000, ewe}, {15'h0000, flags_we});
		check("pc_load", 16'h0001, {15'h0000, pc_load});
		check("req_ready at done", 16'h0001, {15'h0000, req_ready});
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin : main
		exec_req_t r;
		int i;
		repeat (16) @(posedge clk);
		#1;
		check("req_ready in reset", 16'h0001, {15'h0000, req_ready});
		check("done in reset", 16'h0000, {15'h0000, done});
		rst_n = 1'b1;
		for (i = 0; i < 600; i++) begin
			rand_req(r);
			if (i % 16 == 0) begin
				r.op = OP_CMP_IMM;
				r.imm = r.first_val;
			end
			if (i == 300) begin
				rst_n = 1'b0;
				req_valid = 1'b0;
				@(posedge clk);
				#1;
				check("res after reset", 16'h0000, res.pc);
				check("flags after reset", 16'h0000, {8'h00, res.flags});
				rst_n = 1'b1;
			end
			run(r);
			if (($random(seed) & 3) == 0) begin
				req_valid = 1'b0;
				@(posedge clk);
				#1;
			end
		end
		req_valid = 1'b0;
		conclude();
	end
endmodule
